// File: test/pae_chan_model.sv
`timescale 1ns/10ps
`default_nettype none
module pae_chan_model
  import pae_pkg::*;
(
  input  wire logic                    core_clk_i,
  input  wire logic signed [VAL_W-1:0] level_i,   // analog level at the input
  output pae_sample_type               sample_o   // converted sample strobe
);
  // ==========================================================
  // conversion every fourth cycle, value held between samples
  logic [1:0] phase_ff;  // conversion pacing
  initial begin
    phase_ff = 2'h0;
    sample_o = '0;
  end
  always @(posedge core_clk_i) begin
    phase_ff <= phase_ff + 2'h1;
    sample_o.valid <= (phase_ff == 2'h3);
    if (phase_ff == 2'h3) begin
      sample_o.value <= level_i;
    end
  end
endmodule : pae_chan_model
`default_nettype wire

// File: test/pae_evaluator_sva.sv
`timescale 1ns/10ps
`default_nettype none
module pae_evaluator_sva
  import pae_pkg::*;
#(
  parameter int TICK_CYCLES = SEC_CYC  // cycles per tick, as in the design
) (
  input wire logic                 core_clk_i,
  input wire logic                 sys_rst_i,
  input wire logic [7:0]           reg_addr_i,
  input wire logic [31:0]          reg_wdata_i,
  input wire logic                 reg_wr_i,
  input wire logic                 reg_rd_i,
  input wire logic [31:0]          reg_rdata_o,
  input wire pae_sample_type       sample_i,
  input wire logic                 source_analog_i,
  input wire logic [SRC_NUM-1:0]   enable_src_i,
  input wire logic [GRP_NUM-1:0]   group_o,
  input wire logic [ALM_NUM-1:0]   alarm_state_o,
  input wire pae_event_type        event_o
);
  // ==========================================================
  // shadow of alarm a configuration word
  logic [23:0] cfg_a_ff;  // last written configuration
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      cfg_a_ff <= 24'h0;
    end else if (reg_wr_i && reg_addr_i == 8'h10) begin
      cfg_a_ff <= reg_wdata_i[23:0];
    end
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  // ==========================================================
  // properties
  sequence s_latched;  // latch alarm a set, always enabled, analog
    alarm_state_o[0] && source_analog_i && cfg_a_ff[7:4] == 4'h0 &&
    (cfg_a_ff[3:0] == 4'h2 || cfg_a_ff[3:0] == 4'h3);
  endsequence
  property p_rd_idle;
    !reg_rd_i |=> reg_rdata_o == 32'h0;
  endproperty
  property p_stat_rd;
    reg_rd_i && reg_addr_i == 8'h00 |=> reg_rdata_o == {30'h0, $past(alarm_state_o)};
  endproperty
  property p_unmapped;
    reg_rd_i && reg_addr_i[7:4] > 4'h2 |=> reg_rdata_o == 32'h0;
  endproperty
  property p_analog;
    !source_analog_i |=> alarm_state_o == 2'h0;
  endproperty
  property p_grp;
    (alarm_state_o == 2'h0) [*2] |-> group_o == 12'h0;
  endproperty
  property p_evt;  // state as it stood when the event was picked
    event_o.valid |-> event_o.state ==
      (event_o.index ? $past(alarm_state_o[1]) : $past(alarm_state_o[0]));
  endproperty
  property p_latch;
    s_latched ##0 !reg_wr_i |=> alarm_state_o[0];
  endproperty
  property p_off;
    cfg_a_ff[7:4] != 4'h0 && !enable_src_i[cfg_a_ff[7:4] - 4'h1] && !reg_wr_i
      |=> !alarm_state_o[0];
  endproperty
  // ==========================================================
  // assertions
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
  a_stat_rd: assert property (p_stat_rd) else $error("state read wrong");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_analog: assert property (p_analog) else $error("alarm on digital source");
  a_grp: assert property (p_grp) else $error("group set with no alarm");
  a_evt: assert property (p_evt) else $error("event state wrong");
  a_latch: assert property (p_latch) else $error("latch dropped without ack");
  a_off: assert property (p_off) else $error("disabled alarm active");
endmodule : pae_evaluator_sva
`default_nettype wire

// File: test/pae_evaluator_tb.sv
`timescale 1ns/10ps
`default_nettype none
module pae_evaluator_tb;
  import pae_pkg::*;
  logic                    core_clk_i, sys_rst_i, reg_wr_i, reg_rd_i, source_analog_i;
  logic [7:0]              reg_addr_i;
  logic [31:0]             reg_wdata_i, reg_rdata_o;
  logic [SRC_NUM-1:0]      enable_src_i;
  logic [GRP_NUM-1:0]      group_o;
  logic [ALM_NUM-1:0]      alarm_state_o;
  pae_event_type           event_o;
  pae_sample_type          sample_s;   // model to design
  logic signed [VAL_W-1:0] level;      // commanded analog level
  int                      mismatches, check_count, ev_n, ev_s;
  // ==========================================================
  // design, channel model
  pae_evaluator #(.TICK_CYCLES(10)) pae_evaluator_i (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .sample_i(sample_s), .source_analog_i(source_analog_i),
    .enable_src_i(enable_src_i), .group_o(group_o), .alarm_state_o(alarm_state_o),
    .event_o(event_o));
  pae_chan_model pae_chan_model_i (.core_clk_i(core_clk_i), .level_i(level),
    .sample_o(sample_s));
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  // counts log events of alarm a
  always @(posedge core_clk_i) begin
    if (event_o.valid === 1'b1 && event_o.index === 1'b0) begin
      ev_n <= ev_n + 1;
      ev_s <= int'(event_o.state);
    end
  end
  // ==========================================================
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk(reg_rdata_o, exp);
  endtask : rd
  task automatic lv(input int v, input int n, input logic [31:0] exp);
    @(posedge core_clk_i);
    level <= 16'(v);
    repeat (n) @(posedge core_clk_i);
    #1;
    chk(32'(alarm_state_o[0]), exp);
  endtask : lv
  task automatic wst(input logic e, input int n);
    for (int i = 0; i < n && alarm_state_o[0] !== e; i++) begin
      @(posedge core_clk_i);
      #1;
    end
    #1;
    chk(32'(alarm_state_o[0]), 32'(e));
  endtask : wst
  task automatic setup(input logic [3:0] k, input logic [3:0] s, input int t, h, tm);
    wr(8'h10, {8'h0, 12'h841, 4'h1, s, k});
    wr(8'h11, 32'(t));
    wr(8'h12, 32'(h));
    wr(8'h13, 32'(tm));
  endtask : setup
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run
  initial begin
    #100000;
    mismatches++;
    complete_run();
  end
  // ==========================================================
  // tests
  initial begin
    {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i, enable_src_i} = '0;
    {mismatches, check_count} = '0;
    source_analog_i = 1'b1;
    level = '0;
    sys_rst_i = 1'b1;
    repeat (20) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    rd(8'h10, 32'h0);
    for (int k = 0; k < 10; k++) begin
      wr(8'h10, 32'(k));
      rd(8'h10, 32'(k));
    end
    wr(8'h30, 32'h5);
    rd(8'h30, 32'h0);
    $display("test registers done");
    setup(4'h0, 4'h0, 100, 10, 0);
    lv(101, 10, 1);
    chk(32'(group_o), 32'h841);
    lv(95, 10, 1);
    lv(90, 10, 0);
    chk(32'(ev_n), 2);
    chk(32'(ev_s), 0);
    rd(8'h00, 32'h2);
    rd(8'h01, 32'h0);
    setup(4'h1, 4'h0, 100, 10, 0);
    lv(50, 10, 1);
    lv(115, 10, 0);
    setup(4'h0, 4'h0, 100, 0, 3);
    lv(50, 10, 0);
    lv(101, 15, 0);
    lv(50, 10, 0);
    lv(101, 15, 0);
    lv(101, 30, 1);
    $display("test process done");
    setup(4'h2, 4'h0, 100, 0, 0);
    lv(120, 10, 1);
    lv(0, 10, 1);
    wr(8'h00, 32'h1);
    lv(0, 3, 0);
    setup(4'h4, 4'h0, 100, 10, 0);
    lv(120, 10, 1);
    lv(95, 10, 0);
    setup(4'h0, 4'h3, 100, 0, 0);
    lv(120, 10, 0);
    enable_src_i <= 15'h0004;
    lv(120, 10, 1);
    enable_src_i <= 15'h0000;
    setup(4'h8, 4'h3, 100, 10, 3);
    lv(120, 10, 0);
    enable_src_i <= 15'h0004;
    lv(120, 15, 0);
    lv(120, 30, 1);
    lv(95, 10, 1);
    lv(85, 10, 0);
    source_analog_i <= 1'b0;
    lv(120, 5, 0);
    source_analog_i <= 1'b1;
    $display("test latch enable delay done");
    setup(4'h6, 4'h0, 0, 0, 0);
    wr(8'h14, 32'd10);
    wr(8'h15, 32'd3);
    wr(8'h16, 32'd0);
    lv(0, 80, 0);
    lv(60, 1, 0);
    wst(1'b1, 40);
    wst(1'b0, 80);
    wr(8'h16, 32'd15);
    for (int i = 0; i < 8; i++) lv(120, 10, 0);
    wr(8'h10, 32'h7);
    wst(1'b1, 80);
    $display("test rate done");
    setup(4'h3, 4'h0, 100, 0, 0);
    lv(50, 10, 1);
    lv(120, 10, 1);
    wr(8'h00, 32'h1);
    lv(120, 3, 0);
    setup(4'h5, 4'h0, 100, 10, 0);
    lv(50, 10, 1);
    lv(105, 10, 0);
    enable_src_i <= 15'h0000;
    setup(4'h9, 4'h3, 100, 10, 3);
    lv(50, 10, 0);
    enable_src_i <= 15'h0004;
    lv(50, 15, 0);
    lv(50, 30, 1);
    $display("test low variants done");
    complete_run();
  end
endmodule : pae_evaluator_tb
bind pae_evaluator pae_evaluator_sva #(.TICK_CYCLES(TICK_CYCLES)) pae_evaluator_sva_i (
  .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .sample_i(sample_i), .source_analog_i(source_analog_i),
  .enable_src_i(enable_src_i), .group_o(group_o), .alarm_state_o(alarm_state_o),
  .event_o(event_o));
`default_nettype wire

// File: verilog/pae_evaluator.sv
// What this block does
// - alarms only for analog sourced channels
// - compare value against trip level
// - time hysteresis must elapse before activation
// - leaving condition restarts time hysteresis
// - annunciate uses trip and time only
// - delayed alarm: trip, hysteresis, delay time
// - delay suppresses activation after enable rises
// - after delay behave as process alarm with no time hysteresis
// - high rate: change above deviation per period
// - low rate: change below deviation per period
// - rate alarm clears after clean period
// - average source before rate evaluation
// - enable follows selected enable source
// - no source selected means always enabled
// - log event on every state change
// - twelve bit group membership per alarm
// - group output ors member alarm states
`timescale 1ns/10ps
`default_nettype none
module pae_evaluator
  import pae_pkg::*;
#(
  parameter int TICK_CYCLES = SEC_CYC     // cycles per second tick
) (
  input  wire logic                 core_clk_i,
  input  wire logic                 sys_rst_i,
  input  wire logic [7:0]           reg_addr_i,      // word address
  input  wire logic [31:0]          reg_wdata_i,
  input  wire logic                 reg_wr_i,
  input  wire logic                 reg_rd_i,
  output logic      [31:0]          reg_rdata_o,     // valid cycle after read
  input  wire pae_sample_type       sample_i,        // sampled channel value
  input  wire logic                 source_analog_i, // channel fed by analog
  input  wire logic [SRC_NUM-1:0]   enable_src_i,    // enable source levels
  output logic      [GRP_NUM-1:0]   group_o,         // group signals
  output logic      [ALM_NUM-1:0]   alarm_state_o,   // alarm states
  output pae_event_type             event_o          // alarm log event
);

  // =========================================================
  // state
  typedef struct packed {
    logic [TICK_W-1:0]       tick_cnt;  // second divider
    logic signed [VAL_W-1:0] value;     // latest sample
    pae_alm_type [ALM_NUM-1:0] alm;     // per alarm state
    logic [GRP_NUM-1:0]      grp;       // group outputs
    logic [31:0]             rdata;     // read data
    pae_event_type           evt;       // log event
  } pae_state_type;

  pae_state_type s_ff;                  // registered state
  pae_state_type nxt_s;                 // next state

  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

  // =========================================================
  // next state
  always_comb begin
    pae_alm_type             c;         // alarm being worked
    logic                    tick;      // one second pulse
    logic [SRC_NUM:0]        src_ext;   // sources with always-on slot
    logic                    en;        // alarm enabled
    logic                    hi;        // high variant
    logic                    is_latch;
    logic                    is_annun;
    logic                    is_rate;
    logic                    is_delay;
    logic signed [VAL_W:0]   v;         // value, widened
    logic signed [VAL_W:0]   lvl;       // trip, widened
    logic signed [VAL_W:0]   hy;        // effective hysteresis
    logic signed [VAL_W:0]   fd;        // filter difference
    logic signed [VAL_W:0]   rd;        // rate difference
    logic        [VAL_W:0]   mag;       // rate magnitude
    logic                    cset;      // trip condition
    logic                    chold;     // hold condition
    logic                    viol;      // rate out of limits
    logic                    old_act;
    logic                    found;     // event already picked
    logic [3:0]              blk;       // address block
    logic [0:0]              ai;        // alarm index of block
    c        = '0;
    tick     = 1'b0;
    src_ext  = '0;
    en       = 1'b0;
    hi       = 1'b0;
    is_latch = 1'b0;
    is_annun = 1'b0;
    is_rate  = 1'b0;
    is_delay = 1'b0;
    v        = '0;
    lvl      = '0;
    hy       = '0;
    fd       = '0;
    rd       = '0;
    mag      = '0;
    cset     = 1'b0;
    chold    = 1'b0;
    viol     = 1'b0;
    old_act  = 1'b0;
    found    = 1'b0;
    blk      = reg_addr_i[7:4];
    ai       = blk[0:0] - 1'b1;
    nxt_s    = s_ff;

    // second divider
    if (s_ff.tick_cnt == TICK_LAST) begin
      nxt_s.tick_cnt = '0;
      tick           = 1'b1;
    end else begin
      nxt_s.tick_cnt = s_ff.tick_cnt + 1'b1;
    end

    // latest sample kept for the comparisons
    if (sample_i.valid) begin
      nxt_s.value = sample_i.value;
    end

    // configuration writes
    if (reg_wr_i && blk != BLK_GLOBAL && blk <= 4'(ALM_NUM)) begin
      case (reg_addr_i[3:0])
        REG_CFG: begin
          nxt_s.alm[ai].kind   = pae_kind_type'(reg_wdata_i[CFG_TYPE_LSB +: 4]);
          nxt_s.alm[ai].sel    = reg_wdata_i[CFG_SEL_LSB +: 4];
          nxt_s.alm[ai].log_en = reg_wdata_i[CFG_LOG_BIT];
          nxt_s.alm[ai].grp    = reg_wdata_i[CFG_GRP_LSB +: GRP_NUM];
        end
        REG_TRIP: nxt_s.alm[ai].trip = reg_wdata_i[VAL_W-1:0];
        REG_HYST: nxt_s.alm[ai].hyst = reg_wdata_i[VAL_W-1:0];
        REG_TIME: nxt_s.alm[ai].tsec = reg_wdata_i[TIM_W-1:0];
        REG_DEV:  nxt_s.alm[ai].dev  = reg_wdata_i[VAL_W-1:0];
        REG_PER:  nxt_s.alm[ai].per  = reg_wdata_i[TIM_W-1:0];
        REG_FLT:  nxt_s.alm[ai].flt  = reg_wdata_i[3:0];
        default:  nxt_s.alm[ai].flt  = nxt_s.alm[ai].flt; // unmapped, ignored
      endcase
    end

    // per alarm evaluation
    src_ext = {enable_src_i, 1'b1};
    v       = {s_ff.value[VAL_W-1], s_ff.value};
    for (int a = 0; a < ALM_NUM; a++) begin
      c        = nxt_s.alm[a];
      old_act  = s_ff.alm[a].active;
      en       = src_ext[c.sel];
      hi       = 1'b0;
      is_latch = 1'b0;
      is_annun = 1'b0;
      is_rate  = 1'b0;
      is_delay = 1'b0;
      case (c.kind)
        hi_proc:  hi = 1'b1;
        lo_proc:  hi = 1'b0;
        hi_latch: begin hi = 1'b1; is_latch = 1'b1; end
        lo_latch: is_latch = 1'b1;
        hi_annun: begin hi = 1'b1; is_annun = 1'b1; end
        lo_annun: is_annun = 1'b1;
        hi_rate:  begin hi = 1'b1; is_rate = 1'b1; end
        lo_rate:  is_rate = 1'b1;
        hi_delay: begin hi = 1'b1; is_delay = 1'b1; end
        lo_delay: is_delay = 1'b1;
        default:  hi = 1'b1;                // spare codes act as high process
      endcase

      // trip and release levels
      lvl   = {c.trip[VAL_W-1], c.trip};
      hy    = is_annun ? '0 : $signed({1'b0, c.hyst});
      cset  = hi ? (v > lvl) : (v < lvl);
      // release levels two bits wider so a large hysteresis cannot wrap
      chold = hi ? ((VAL_W+2)'(v) > (VAL_W+2)'(lvl) - (VAL_W+2)'(hy))
                 : ((VAL_W+2)'(v) < (VAL_W+2)'(lvl) + (VAL_W+2)'(hy));

      // delay after enable turns on
      if (en && !c.en_q) begin
        c.dly = is_delay ? c.tsec : '0;
      end else if (tick && c.dly != '0) begin
        c.dly = c.dly - 1'b1;
      end
      c.en_q = en;

      // averaging ahead of the rate check
      if (sample_i.valid) begin
        fd     = {sample_i.value[VAL_W-1], sample_i.value} - {c.filt[VAL_W-1], c.filt};
        c.filt = c.filt + VAL_W'(fd >>> c.flt);
      end

      if (!source_analog_i || !en) begin
        c.active = 1'b0;
        c.tcnt   = '0;
        c.pcnt   = '0;
        c.ref_v  = c.filt;
      end else if (is_rate) begin
        if (tick) begin
          if (c.pcnt + 1'b1 >= c.per) begin
            c.pcnt   = '0;
            rd       = {c.filt[VAL_W-1], c.filt} - {c.ref_v[VAL_W-1], c.ref_v};
            mag      = rd[VAL_W] ? unsigned'(-rd) : unsigned'(rd); // full width magnitude
            viol     = hi ? (mag > {1'b0, c.dev})
                          : (mag < {1'b0, c.dev});
            c.active = viol;
            c.ref_v  = c.filt;
          end else begin
            c.pcnt = c.pcnt + 1'b1;
          end
        end
      end else if (is_delay && c.dly != '0) begin
        c.active = 1'b0;
        c.tcnt   = '0;
      end else if (c.active) begin
        c.tcnt = '0;
        if (is_latch) begin
          if (reg_wr_i && blk == BLK_GLOBAL && reg_addr_i[3:0] == REG_STAT
              && reg_wdata_i[a]) begin
            c.active = 1'b0;
          end
        end else if (!chold) begin
          c.active = 1'b0;
        end
      end else if (cset) begin
        if (is_delay || c.tcnt >= c.tsec) begin
          c.active = 1'b1;
        end else if (tick) begin
          c.tcnt = c.tcnt + 1'b1;
        end
      end else begin
        c.tcnt = '0;
      end

      // log request for any change of state
      if (c.log_en && (c.active != old_act)) begin
        c.pend = 1'b1;
      end
      nxt_s.alm[a] = c;
    end

    // one log event per cycle, lowest alarm first
    nxt_s.evt = '0;
    for (int a = 0; a < ALM_NUM; a++) begin
      if (s_ff.alm[a].pend && !found) begin
        found           = 1'b1;
        nxt_s.evt.valid = 1'b1;
        nxt_s.evt.index = a[0:0];
        nxt_s.evt.state = s_ff.alm[a].active;
        // a change in this cycle keeps the request
        if (nxt_s.alm[a].active == s_ff.alm[a].active) begin
          nxt_s.alm[a].pend = 1'b0;
        end
      end
    end

    // group outputs
    nxt_s.grp = '0;
    for (int a = 0; a < ALM_NUM; a++) begin
      if (nxt_s.alm[a].active) begin
        nxt_s.grp = nxt_s.grp | nxt_s.alm[a].grp;
      end
    end

    // register reads, answered next cycle
    nxt_s.rdata = '0;
    if (reg_rd_i) begin
      if (blk == BLK_GLOBAL) begin
        case (reg_addr_i[3:0])
          REG_STAT: nxt_s.rdata = 32'(alarm_state_o);
          REG_GRP:  nxt_s.rdata = 32'(s_ff.grp);
          default:  nxt_s.rdata = '0;                  // unmapped reads zero
        endcase
      end else if (blk <= 4'(ALM_NUM)) begin
        case (reg_addr_i[3:0])
          REG_CFG:  nxt_s.rdata = {8'h00, s_ff.alm[ai].grp, 3'h0,
                                   s_ff.alm[ai].log_en, s_ff.alm[ai].sel,
                                   s_ff.alm[ai].kind};
          REG_TRIP: nxt_s.rdata = 32'(unsigned'(s_ff.alm[ai].trip));
          REG_HYST: nxt_s.rdata = 32'(s_ff.alm[ai].hyst);
          REG_TIME: nxt_s.rdata = 32'(s_ff.alm[ai].tsec);
          REG_DEV:  nxt_s.rdata = 32'(s_ff.alm[ai].dev);
          REG_PER:  nxt_s.rdata = 32'(s_ff.alm[ai].per);
          REG_FLT:  nxt_s.rdata = 32'(s_ff.alm[ai].flt);
          default:  nxt_s.rdata = '0;
        endcase
      end
    end
  end

  // =========================================================
  // state register
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // =========================================================
  // outputs
  always_comb begin
    for (int a = 0; a < ALM_NUM; a++) begin
      alarm_state_o[a] = s_ff.alm[a].active;
    end
  end
  assign group_o     = s_ff.grp;
  assign event_o     = s_ff.evt;
  assign reg_rdata_o = s_ff.rdata;

endmodule : pae_evaluator
`default_nettype wire

// File: verilog/pae_pkg.sv
`default_nettype none
package pae_pkg;
  // =========================================================
  // sizes
  localparam int ALM_NUM   = 2;        // alarms per channel
  localparam int GRP_NUM   = 12;       // group outputs
  localparam int SRC_NUM   = 15;       // selectable enable sources
  localparam int VAL_W     = 16;       // engineering value width
  localparam int TIM_W     = 16;       // second counters
  // =========================================================
  // timing
  localparam int CLK_NS    = 10;       // core clock period
  localparam int SEC_NS    = 1000000000; // one second in ns
  localparam int SEC_CYC   = SEC_NS / CLK_NS; // cycles per second
  localparam int TICK_W    = 27;       // second divider width
  // =========================================================
  // register map (word addresses)
  localparam logic [3:0] BLK_GLOBAL = 4'h0; // global block
  localparam logic [3:0] REG_STAT   = 4'h0; // rd: states, wr: ack bits
  localparam logic [3:0] REG_GRP    = 4'h1; // rd: group outputs
  localparam logic [3:0] REG_CFG    = 4'h0; // per alarm configuration
  localparam logic [3:0] REG_TRIP   = 4'h1; // trip level
  localparam logic [3:0] REG_HYST   = 4'h2; // value hysteresis
  localparam logic [3:0] REG_TIME   = 4'h3; // time hysteresis or delay, s
  localparam logic [3:0] REG_DEV    = 4'h4; // rate deviation
  localparam logic [3:0] REG_PER    = 4'h5; // rate period, s
  localparam logic [3:0] REG_FLT    = 4'h6; // rate filter shift
  // configuration field positions
  localparam int CFG_TYPE_LSB = 0;    // alarm type, 4 bits
  localparam int CFG_SEL_LSB  = 4;    // enable source select, 4 bits
  localparam int CFG_LOG_BIT  = 8;    // log enable
  localparam int CFG_GRP_LSB  = 12;   // group mask, 12 bits
  // =========================================================
  // types
  typedef enum logic [3:0] {
    hi_proc, lo_proc, hi_latch, lo_latch, hi_annun,
    lo_annun, hi_rate, lo_rate, hi_delay, lo_delay
  } pae_kind_type;

  typedef struct packed {
    logic                    valid; // new sample strobe
    logic signed [VAL_W-1:0] value; // engineering value
  } pae_sample_type;

  typedef struct packed {
    logic       valid;              // one-cycle log strobe
    logic [0:0] index;              // alarm that changed
    logic       state;              // its new state
  } pae_event_type;

  typedef struct packed {
    pae_kind_type            kind;  // alarm type
    logic [3:0]              sel;   // enable source select
    logic                    log_en;
    logic [GRP_NUM-1:0]      grp;   // group membership
    logic signed [VAL_W-1:0] trip;
    logic        [VAL_W-1:0] hyst;
    logic        [TIM_W-1:0] tsec;  // time hysteresis / delay
    logic        [VAL_W-1:0] dev;
    logic        [TIM_W-1:0] per;
    logic [3:0]              flt;
    logic                    active;
    logic        [TIM_W-1:0] tcnt;  // time hysteresis count
    logic        [TIM_W-1:0] dly;   // remaining delay
    logic                    en_q;  // enable of last cycle
    logic        [TIM_W-1:0] pcnt;  // period count
    logic signed [VAL_W-1:0] filt;  // averaged value
    logic signed [VAL_W-1:0] ref_v; // value at period start
    logic                    pend;  // log event waiting
  } pae_alm_type;
endpackage : pae_pkg
`default_nettype wire
